//--- design/aceb_bus.sv
// channel expansion bus controller with AXI4-Lite register slave
// ************************************************************
// Overview of operation
// - drive the 8-bit channel address onto the bus, 256 channels
// - address register auto-sequences and is loadable by software
// - one address broadcast to all boards, no per-board path
// - lowest 8 or 16 addresses select local input channels
// - addressing serves up to ten slave boards on one cable
// - trigger line is shared open-collector wired-OR
// - external trigger starts one conversion or a full scan
// - local timer output may serve as the trigger source
// - host software command starts a conversion
// - slave settling-delay line holds off the conversion
// - conversion and scan done events always go to local irq lines
// - start source: external, timer, result read or host command
// - trigger starts one conversion or one whole scan
// - sequencer increments after each conversion or holds
// - scan steps from start channel up to final channel
// - rescan reloads the start channel at end of scan
// - external trigger waits for a falling edge first
// ************************************************************
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module aceb_bus #(
  parameter int NUM_BOARDS = aceb_pkg::MAX_BOARDS,
  parameter int DATA_W     = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // expansion bus
  output logic [7:0]       chan_addr,
  input  wire logic        trig_in,
  output logic             trig_out,
  output logic             trig_oe,
  input  wire logic        settle_busy,
  input  wire logic        timer_tick,
  // converter
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  output logic             local_sel,
  // local interrupt controller
  output logic             eoc_irq,
  output logic             eos_irq
);

  initial begin
    if (NUM_BOARDS < 1 || NUM_BOARDS > aceb_pkg::MAX_BOARDS)
      $error("NUM_BOARDS out of range");
    if (DATA_W < 1 || DATA_W > 16)
      $error("DATA_W out of range");
  end

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  logic [1:0] pins_s;
  aceb_sync #(.W(2)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in ({settle_busy, trig_in}),
    .sync_out (pins_s)
  );

  logic trig_s;
  logic settle_s;
  logic trig_prev_q;
  logic trig_fall;
  assign trig_s   = pins_s[0];
  assign settle_s = pins_s[1];
  assign trig_fall = trig_prev_q & ~trig_s;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0]               start_q;
  logic [7:0]               final_q;
  logic [aceb_pkg::CTRL_W-1:0] ctrl_q;
  logic [7:0]               chan_q;
  logic [15:0]              data_q;
  logic                     eoc_q;
  logic                     eos_q;
  logic                     run_q;
  logic                     busy;

  aceb_pkg::aceb_src_t src;
  assign src = aceb_pkg::aceb_src_t'(ctrl_q[aceb_pkg::CTRL_SRC_LO +: 2]);

  function automatic logic is_local(input logic [7:0] a, input logic diff);
    is_local = diff ? (a < aceb_pkg::LOCAL_DIFF_CH) : (a < aceb_pkg::LOCAL_SE_CH);
  endfunction

  // ************************************************************
  // axi4-lite handshake
  // ************************************************************
  logic [7:0]  aw_q;
  logic        aw_have_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        w_have_q;
  logic        wr_go;
  logic        rd_go;
  logic        rd_data_pulse;

  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_q          <= 8'h00;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (ce) begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q      <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q > aceb_pkg::REG_CHAN) || (aw_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_start;
  logic wr_final;
  logic wr_ctrl;
  logic wr_cmd;
  always_comb begin
    wr_start = 1'b0;
    wr_final = 1'b0;
    wr_ctrl  = 1'b0;
    wr_cmd   = 1'b0;
    if (wr_go && ws_q[0]) begin
      if (aw_q == aceb_pkg::REG_START) begin
        wr_start = 1'b1;
      end else if (aw_q == aceb_pkg::REG_FINAL) begin
        wr_final = 1'b1;
      end else if (aw_q == aceb_pkg::REG_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (aw_q == aceb_pkg::REG_CMD) begin
        wr_cmd = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= aceb_pkg::START_RESET;
      final_q <= aceb_pkg::FINAL_RESET;
      ctrl_q  <= aceb_pkg::CTRL_RESET;
    end else if (ce) begin
      if (wr_start) start_q <= w_q[7:0];
      if (wr_final) final_q <= w_q[7:0];
      if (wr_ctrl)  ctrl_q  <= w_q[aceb_pkg::CTRL_W-1:0];
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      rd_data_pulse <= 1'b0;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      rd_data_pulse <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == aceb_pkg::REG_START) begin
          s_axi_rdata[7:0] <= start_q;
        end else if (s_axi_araddr == aceb_pkg::REG_FINAL) begin
          s_axi_rdata[7:0] <= final_q;
        end else if (s_axi_araddr == aceb_pkg::REG_CTRL) begin
          s_axi_rdata[aceb_pkg::CTRL_W-1:0] <= ctrl_q;
        end else if (s_axi_araddr == aceb_pkg::REG_STATUS) begin
          s_axi_rdata[aceb_pkg::ST_EOC]   <= eoc_q;
          s_axi_rdata[aceb_pkg::ST_EOS]   <= eos_q;
          s_axi_rdata[aceb_pkg::ST_BUSY]  <= busy;
          s_axi_rdata[aceb_pkg::ST_LOCAL] <= local_sel;
          s_axi_rdata[aceb_pkg::ST_RUN]   <= run_q;
        end else if (s_axi_araddr == aceb_pkg::REG_CMD) begin
          s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_araddr == aceb_pkg::REG_DATA) begin
          s_axi_rdata[15:0] <= data_q;
          rd_data_pulse     <= 1'b1;
        end else if (s_axi_araddr == aceb_pkg::REG_CHAN) begin
          s_axi_rdata[7:0] <= chan_q;
        end else begin
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // start logic and sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    ACEB_IDLE,
    ACEB_SETTLE,
    ACEB_CONV
  } aceb_state_t;

  aceb_state_t state_q;
  logic [3:0]  hold_cnt_q;
  logic        trig_ev;
  logic        host_cmd;
  logic        last_chan;
  assign busy = (state_q != ACEB_IDLE);
  assign host_cmd = wr_cmd & w_q[aceb_pkg::CMD_START];
  assign last_chan = (chan_q == final_q);

  always_comb begin
    trig_ev = 1'b0;
    if (!ctrl_q[aceb_pkg::CTRL_INHIBIT]) begin
      case (src)
        aceb_pkg::SRC_EXT:   trig_ev = trig_fall;
        aceb_pkg::SRC_TIMER: trig_ev = trig_fall;
        aceb_pkg::SRC_READ:  trig_ev = rd_data_pulse;
        default:             trig_ev = 1'b0;
      endcase
    end
    // a running scan starts its next sample by itself
    if (run_q) trig_ev = 1'b1;
    trig_ev = trig_ev | host_cmd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // low at reset, so the idle-high pin gives no false edge
      trig_prev_q <= 1'b0;
    end else if (ce) begin
      trig_prev_q <= trig_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= ACEB_IDLE;
      conv_start <= 1'b0;
      hold_cnt_q <= 4'h0;
      data_q     <= 16'h0000;
    end else if (ce) begin
      conv_start <= 1'b0;
      case (state_q)
        ACEB_IDLE: begin
          if (trig_ev && !(eos_q && !ctrl_q[aceb_pkg::CTRL_RESCAN])) begin
            state_q    <= ACEB_SETTLE;
            hold_cnt_q <= 4'(aceb_pkg::SETTLE_BLIND);
          end
        end
        ACEB_SETTLE: begin
          // settle line is stale until the new address has gone out and been synced
          if (hold_cnt_q != 4'h0) begin
            hold_cnt_q <= hold_cnt_q - 4'h1;
          end else if (!settle_s) begin
            state_q    <= ACEB_CONV;
            conv_start <= 1'b1;
          end
        end
        ACEB_CONV: begin
          if (conv_done) begin
            data_q  <= conv_data;
            state_q <= ACEB_IDLE;
          end
        end
        default: state_q <= ACEB_IDLE;
      endcase
    end
  end

  logic conv_end;
  assign conv_end = (state_q == ACEB_CONV) & conv_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_q <= aceb_pkg::START_RESET;
      run_q  <= 1'b0;
      eoc_q  <= 1'b0;
      eos_q  <= 1'b0;
    end else if (ce) begin
      if (wr_cmd && w_q[aceb_pkg::CMD_CLR]) begin
        eoc_q <= 1'b0;
        eos_q <= 1'b0;
      end
      if (wr_start) begin
        chan_q <= w_q[7:0];
        eos_q  <= 1'b0;
      end
      if (state_q == ACEB_IDLE && trig_ev && ctrl_q[aceb_pkg::CTRL_SCAN]) begin
        run_q <= 1'b1;
      end
      if (conv_end) begin
        eoc_q <= 1'b1;
        if (last_chan) begin
          eos_q <= 1'b1;
          run_q <= 1'b0;
          if (ctrl_q[aceb_pkg::CTRL_RESCAN]) chan_q <= start_q;
        end else if (!ctrl_q[aceb_pkg::CTRL_HOLD]) begin
          chan_q <= chan_q + 8'h01;
        end
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_addr <= 8'h00;
      local_sel <= 1'b1;
      trig_out  <= 1'b0;
      trig_oe   <= 1'b0;
      eoc_irq   <= 1'b0;
      eos_irq   <= 1'b0;
    end else if (ce) begin
      chan_addr <= chan_q;
      local_sel <= is_local(chan_q, ctrl_q[aceb_pkg::CTRL_DIFF]);
      trig_out  <= 1'b0;
      trig_oe   <= (src == aceb_pkg::SRC_TIMER) & timer_tick;
      eoc_irq   <= conv_end;
      eos_irq   <= conv_end & last_chan;
    end
  end

endmodule : aceb_bus

`default_nettype wire

//--- design/aceb_pkg.sv
// package of constants for the channel expansion bus block
package aceb_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] REG_START   = 8'h00;
  localparam logic [7:0] REG_FINAL   = 8'h04;
  localparam logic [7:0] REG_CTRL    = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_CMD     = 8'h10;
  localparam logic [7:0] REG_DATA    = 8'h14;
  localparam logic [7:0] REG_CHAN    = 8'h18;

  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int CTRL_SRC_LO     = 0;   // 2-bit start source
  localparam int CTRL_SCAN       = 2;   // one scan per trigger
  localparam int CTRL_HOLD       = 3;   // inhibit address increment
  localparam int CTRL_RESCAN     = 4;
  localparam int CTRL_INHIBIT    = 5;   // ext, timer and read starts inhibited; host command still starts
  localparam int CTRL_DIFF       = 6;   // 8 local channels instead of 16
  localparam int CTRL_W          = 7;

  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [7:0] START_RESET = 8'h00;
  localparam logic [7:0] FINAL_RESET = 8'h00;

  // command register bits
  localparam int CMD_START = 0;
  localparam int CMD_CLR   = 1;

  // status bit positions
  localparam int ST_EOC    = 0;
  localparam int ST_EOS    = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_LOCAL  = 3;
  localparam int ST_RUN    = 4;

  localparam logic [7:0] LOCAL_SE_CH   = 8'h10;
  localparam logic [7:0] LOCAL_DIFF_CH = 8'h08;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ       = 100;
  localparam int CONV_TIME_NS  = 2000;
  localparam int CONV_CYCLES   = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_BLIND  = 3;   // cycles until the synced settle line sees a new address
  localparam int MAX_BOARDS    = 10;

  typedef enum logic [1:0] {
    SRC_EXT,
    SRC_TIMER,
    SRC_READ,
    SRC_HOST
  } aceb_src_t;

endpackage : aceb_pkg

//--- design/aceb_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module aceb_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : aceb_sync

`default_nettype wire

//--- verification/aceb_bus_properties.sv
// port-level checks for the channel expansion bus controller
`timescale 1ns/100ps
`default_nettype none

module aceb_bus_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  chan_addr,
  input wire logic        trig_out,
  input wire logic        trig_oe,
  input wire logic        settle_busy,
  input wire logic        timer_tick,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic        local_sel,
  input wire logic        eoc_irq
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence done_seen;
    $past(conv_done) || $past(conv_done, 2) || $past(conv_done, 3) || $past(conv_done, 4);
  endsequence
  sequence settling;
    settle_busy [*4];
  endsequence
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_settle_hold: assert property (settling |-> !conv_start)
    else $error("start during settling");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start not a pulse");
  a_eoc_cause: assert property (eoc_irq |-> done_seen)
    else $error("eoc without conversion");
  a_done_eoc: assert property (conv_done |-> ##[1:3] eoc_irq)
    else $error("eoc missing");
  a_trig_wired: assert property (trig_out == 1'b0)
    else $error("trigger driven high");
  a_trig_timer: assert property (trig_oe |-> $past(timer_tick) || $past(timer_tick, 2))
    else $error("trigger pull without tick");
  a_local_low: assert property ($stable(chan_addr) && chan_addr < 8'h08 |-> local_sel)
    else $error("local channel not local");
  a_board_high: assert property ($stable(chan_addr) && chan_addr >= 8'h10 |-> !local_sel)
    else $error("board channel marked local");
  a_step_cause: assert property (chan_addr == $past(chan_addr) + 8'h01 |-> done_seen)
    else $error("address stepped without conversion");
endmodule : aceb_bus_props

bind aceb_bus aceb_bus_props u_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .chan_addr,
  .trig_out, .trig_oe, .settle_busy, .timer_tick, .conv_start, .conv_done, .local_sel,
  .eoc_irq);

`default_nettype wire

//--- verification/aceb_mux_model.sv
// slave multiplexer boards and converter seen from the expansion bus
`timescale 1ns/100ps
`default_nettype none

module aceb_mux_model #(
  parameter int BOARDS = 10,
  parameter int SETTLE = 6,
  parameter int CONV   = 8
) (
  input  wire logic              aclk,
  input  wire logic [7:0]        chan_addr,
  input  wire logic              ext_pull,
  input  wire logic              conv_start,
  output logic                   trig_pull,
  output logic                   settle_busy,
  output logic [BOARDS-1:0]      board_sel,
  output logic                   conv_done,
  output logic [15:0]            conv_data
);
  // ********
  // boards
  // ********
  logic [7:0]  last_q = 8'h00;
  logic [15:0] res    = 16'h0000;
  int          cnt    = 0;
  int          lat    = 0;
  initial conv_done = 1'b0;
  // each board owns 16 channels above the local ones
  always_comb begin
    for (int i = 0; i < BOARDS; i++) begin
      board_sel[i] = int'(chan_addr) >= 16 * (i + 1) && int'(chan_addr) < 16 * (i + 2);
    end
  end
  assign trig_pull = ext_pull;
  assign settle_busy = cnt != 0 || (chan_addr != last_q && |board_sel);
  always @(posedge aclk) begin
    last_q <= chan_addr;
    if (chan_addr != last_q && |board_sel) cnt <= SETTLE;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    if (conv_start) lat <= CONV;
    else if (lat != 0) lat <= lat - 1;
    if (lat == 1) begin
      conv_done <= 1'b1;
      res       <= {8'h5a, chan_addr};
    end
  end
  // result lines carry garbage outside the done pulse
  assign conv_data = conv_done ? res : ~res;
endmodule : aceb_mux_model

`default_nettype wire

//--- verification/adc_channel_expansion_bus_tb.sv
// self-checking bench for the channel expansion bus controller
`timescale 1ns/100ps
`default_nettype none

module adc_channel_expansion_bus_tb;
  logic        aclk, aresetn, ce, timer_tick, ext_pull, trig_pull, trig_in;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, chan_addr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic        trig_out, trig_oe, settle_busy, conv_start, conv_done, local_sel;
  logic        eoc_irq, eos_irq;
  logic [15:0] conv_data;
  logic [9:0]  mux_sel;
  logic [7:0]  chq[$];
  int          fails, checked, eoc_n, eos_n;

  aceb_bus dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chan_addr, .trig_in, .trig_out, .trig_oe, .settle_busy,
    .timer_tick, .conv_start, .conv_done, .conv_data, .local_sel, .eoc_irq, .eos_irq);
  aceb_mux_model mux (.aclk, .chan_addr, .ext_pull, .conv_start, .trig_pull, .settle_busy,
    .board_sel(mux_sel), .conv_done, .conv_data);
  // open-collector line with pull-up
  assign trig_in = !((trig_oe && !trig_out) || trig_pull);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ********
  // helpers
  // ********
  task automatic test_done;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  function automatic logic [9:0] exp_sel(input logic [7:0] c);
    exp_sel = 10'h000;
    if (c >= 8'h10 && c < 8'hb0) exp_sel[(c - 8'h10) >> 4] = 1'b1;
  endfunction : exp_sel
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 2'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wt(input int e, input int s);
    int n;
    n = 0;
    while ((eoc_n < e || eos_n < s) && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk(n < 3000, 1'b1);
  endtask : wt
  task automatic clr;
    chq.delete();
    eoc_n = 0;
    eos_n = 0;
  endtask : clr
  always @(posedge aclk) begin
    if (eoc_irq) eoc_n <= eoc_n + 1;
    if (eos_irq) eos_n <= eos_n + 1;
    if (conv_start) begin
      chq.push_back(chan_addr);
      chk(mux_sel, exp_sel(chan_addr));
    end
  end

  // ********
  // scenarios
  // ********
  task automatic t_regs;
    chk(chan_addr, 8'h00);
    chk(local_sel, 1'b1);
    wr(aceb_pkg::REG_START, 32'h2c);
    rd(aceb_pkg::REG_CHAN);
    chk(rd_d[7:0], 8'h2c);
    chk(chan_addr, 8'h2c);
    rd(8'h1c);
    chk(rd_r, 2'h2);
  endtask : t_regs
  task automatic t_host_scan;
    wr(aceb_pkg::REG_FINAL, 32'h11);
    wr(aceb_pkg::REG_CTRL, 32'h07);
    wr(aceb_pkg::REG_START, 32'h0e);
    clr();
    wr(aceb_pkg::REG_CMD, 32'h01);
    wt(4, 1);
    chk(chq.size(), 4);
    for (int i = 0; i < 4; i++) chk(chq[i], 8'h0e + i);
    rd(aceb_pkg::REG_STATUS);
    chk(rd_d[aceb_pkg::ST_EOS], 1'b1);
    chk(chan_addr, 8'h11);
    chk(eos_n, 1);
  endtask : t_host_scan
  task automatic t_ext_hold;
    wr(aceb_pkg::REG_CTRL, 32'h08);
    wr(aceb_pkg::REG_FINAL, 32'h27);
    wr(aceb_pkg::REG_START, 32'h25);
    clr();
    ext_pull <= 1'b1;
    wt(1, 0);
    repeat (40) @(posedge aclk);
    ext_pull <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(eoc_n, 1);
    ext_pull <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_pull <= 1'b0;
    wt(2, 0);
    chk(chq[1], 8'h25);
    chk(chan_addr, 8'h25);
  endtask : t_ext_hold
  task automatic t_timer_rescan;
    wr(aceb_pkg::REG_CTRL, 32'h15);
    wr(aceb_pkg::REG_FINAL, 32'h31);
    wr(aceb_pkg::REG_START, 32'h30);
    clr();
    timer_tick <= 1'b1;
    @(posedge aclk);
    timer_tick <= 1'b0;
    wt(2, 1);
    chk(chq[1], 8'h31);
    chk(chan_addr, 8'h30);
  endtask : t_timer_rescan
  task automatic t_read_src;
    wr(aceb_pkg::REG_CTRL, 32'h0a);
    wr(aceb_pkg::REG_START, 32'h42);
    clr();
    rd(aceb_pkg::REG_DATA);
    wt(1, 0);
    rd(aceb_pkg::REG_DATA);
    chk(rd_d[15:0], 16'h5a42);
    wt(2, 0);
  endtask : t_read_src

  initial begin
    {aresetn, timer_tick, ext_pull, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    fails = 0;
    checked = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_host_scan();
    t_ext_hold();
    t_timer_rescan();
    t_read_src();
    test_done();
  end
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule : adc_channel_expansion_bus_tb

`default_nettype wire
